// ===== rtl/pscf_core.sv
// Operating-point request/status registers and per-processor feedback counters.
// Assumes model register and query requests come from core logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
module pscf_core
    import pscf_pkg::*;
#(
    parameter logic [15:0] OP_POINT_MASK = 16'hFFFF
)
(
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire pscf_msr_req_type   msr_req,
    output pscf_msr_rsp_type        msr_rsp,
    input  wire pscf_query_req_type query_req,
    output pscf_query_rsp_type      query_rsp,
    input  wire logic               active_power_state,
    input  wire logic               delivered_perf_tick,
    output logic [15:0]             op_point_apply,
    output logic                    transition_busy
);

    // ==========================================================
    // control group
    logic           misc_feature_enable;
    logic [15:0]    operating_point_request;
    logic [15:0]    operating_point_current;
    logic           pending;
    pscf_state_type state;
    logic           next_misc_feature_enable;
    logic [15:0]    next_operating_point_request;
    logic [15:0]    next_operating_point_current;
    logic           next_pending;
    pscf_state_type next_state;
    logic [15:0]    next_op_point_apply;
    logic           start_transition;
    logic           settle_done;
    logic           wr_request;

    assign wr_request = msr_req.wr && (msr_req.addr == PSCF_ADDR_OP_REQUEST);

    always_comb begin
        next_misc_feature_enable     = misc_feature_enable;
        next_operating_point_request = operating_point_request;
        next_operating_point_current = operating_point_current;
        next_op_point_apply          = op_point_apply;
        next_state                   = state;
        start_transition             = 1'b0;
        if (msr_req.wr && msr_req.addr == PSCF_ADDR_MISC_ENABLE) begin
            next_misc_feature_enable = msr_req.data[PSCF_MISC_TRANSITION_BIT]; // R02
        end
        if (wr_request) begin
            next_operating_point_request = msr_req.data[15:0]; // R03
        end
        unique case (state)
            PSCF_ST_IDLE: begin
                // a stored target waits here while the feature is off
                if (pending && misc_feature_enable) begin // R02
                    start_transition    = 1'b1; // R03
                    next_op_point_apply = operating_point_request & OP_POINT_MASK; // R07
                    next_state          = PSCF_ST_SETTLE;
                end
            end
            PSCF_ST_SETTLE: begin
                if (settle_done) begin
                    next_operating_point_current = op_point_apply; // R06 R16
                    next_state                   = PSCF_ST_IDLE;
                end
            end
        endcase
        // new write wins over the consume of the old one
        next_pending = wr_request || (pending && !start_transition); // R04
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            misc_feature_enable     <= PSCF_MISC_ENABLE_RESET; // R02
            operating_point_request <= PSCF_OP_POINT_RESET;
            operating_point_current <= PSCF_OP_POINT_RESET;
            op_point_apply          <= PSCF_OP_POINT_RESET;
            pending                 <= 1'b0;
            state                   <= PSCF_ST_IDLE;
        end else begin
            misc_feature_enable     <= next_misc_feature_enable;
            operating_point_request <= next_operating_point_request;
            operating_point_current <= next_operating_point_current;
            op_point_apply          <= next_op_point_apply;
            pending                 <= next_pending;
            state                   <= next_state;
        end
    end

    assign transition_busy = state;

    pscf_settle_timer u_settle (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .start    (start_transition),
        .busy     (),
        .done     (settle_done)
    );

    // ==========================================================
    // feedback counter group
    logic [63:0] fixed_rate_feedback_count;
    logic [63:0] actual_rate_feedback_count;
    logic [7:0]  ref_div;
    logic [63:0] next_fixed;
    logic [63:0] next_actual;
    logic [7:0]  next_ref_div;
    logic        ref_tick;
    logic        fixed_inc;
    logic        actual_inc;
    logic        overflow;

    assign ref_tick   = (ref_div == 8'(PSCF_REF_DIV_CYCLES - 1));
    assign fixed_inc  = active_power_state && ref_tick; // R09 R11
    assign actual_inc = active_power_state && delivered_perf_tick; // R10 R11
    assign overflow   = (fixed_inc && (&fixed_rate_feedback_count))
                     || (actual_inc && (&actual_rate_feedback_count));

    always_comb begin
        next_ref_div = ref_tick ? 8'h00 : ref_div + 8'h01; // R09
        next_fixed   = fixed_rate_feedback_count + {63'h0, fixed_inc};
        next_actual  = actual_rate_feedback_count + {63'h0, actual_inc};
        if (overflow) begin
            next_fixed  = PSCF_COUNT_RESET; // R12
            next_actual = PSCF_COUNT_RESET; // R12
        end
        // a software write replaces only its own counter
        if (msr_req.wr && msr_req.addr == PSCF_ADDR_FIXED_RATE) begin
            next_fixed = msr_req.data; // R13
        end
        if (msr_req.wr && msr_req.addr == PSCF_ADDR_ACTUAL_RATE) begin
            next_actual = msr_req.data; // R13
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fixed_rate_feedback_count  <= PSCF_COUNT_RESET;
            actual_rate_feedback_count <= PSCF_COUNT_RESET;
            ref_div                    <= 8'h00;
        end else begin
            fixed_rate_feedback_count  <= next_fixed;
            actual_rate_feedback_count <= next_actual;
            ref_div                    <= next_ref_div;
        end
    end

    // ==========================================================
    // read and query answers
    pscf_msr_rsp_type   next_msr_rsp;
    pscf_query_rsp_type next_query_rsp;

    always_comb begin
        next_msr_rsp       = '0;
        next_msr_rsp.valid = msr_req.rd || msr_req.wr;
        next_msr_rsp.hit   = 1'b1;
        unique case (msr_req.addr)
            PSCF_ADDR_OP_REQUEST:  next_msr_rsp.data = {48'h0, operating_point_request}; // R05
            PSCF_ADDR_OP_CURRENT:  next_msr_rsp.data = {48'h0, operating_point_current}; // R06
            PSCF_ADDR_MISC_ENABLE:
                next_msr_rsp.data[PSCF_MISC_TRANSITION_BIT] = misc_feature_enable;
            PSCF_ADDR_FIXED_RATE:  next_msr_rsp.data = fixed_rate_feedback_count;
            PSCF_ADDR_ACTUAL_RATE: next_msr_rsp.data = actual_rate_feedback_count;
            default:               next_msr_rsp.hit  = 1'b0;
        endcase
        // writes answer with hit only; data is meaningful on reads
        if (!msr_req.rd) begin
            next_msr_rsp.data = 64'h0;
        end
        next_query_rsp       = '0;
        next_query_rsp.valid = query_req.valid;
        if (query_req.leaf == PSCF_LEAF_FEATURES) begin
            next_query_rsp.ecx[PSCF_ID_TRANSITION_BIT] = 1'b1; // R01
        end
        if (query_req.leaf == PSCF_LEAF_POWER) begin
            next_query_rsp.ecx[PSCF_ID_FEEDBACK_BIT] = 1'b1; // R08
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            msr_rsp   <= '0;
            query_rsp <= '0;
        end else begin
            msr_rsp   <= next_msr_rsp;
            query_rsp <= next_query_rsp;
        end
    end

    // ==========================================================
    // checks
    logic sw_count_wr;
    assign sw_count_wr = msr_req.wr && (msr_req.addr == PSCF_ADDR_FIXED_RATE
                                     || msr_req.addr == PSCF_ADDR_ACTUAL_RATE);

    AST_ID_TRANSITION: assert property (@(posedge core_clk) disable iff (sys_rst) // R01
        query_req.valid && query_req.leaf == PSCF_LEAF_FEATURES |=> query_rsp.valid && query_rsp.ecx[7])
        else $error("transition feature not advertised");
    AST_ID_FEEDBACK: assert property (@(posedge core_clk) disable iff (sys_rst) // R08
        query_req.valid && query_req.leaf == PSCF_LEAF_POWER |=> query_rsp.ecx[0])
        else $error("feedback counters not advertised");
    AST_RESET_DISABLES: assert property (@(posedge core_clk) // R02
        sys_rst |=> !misc_feature_enable)
        else $error("reset left the feature enabled");
    AST_NO_START_DISABLED: assert property (@(posedge core_clk) disable iff (sys_rst) // R02
        state == PSCF_ST_IDLE && !misc_feature_enable |=> state == PSCF_ST_IDLE)
        else $error("transition started while disabled");
    AST_REQUEST_STARTS: assert property (@(posedge core_clk) disable iff (sys_rst) // R03
        wr_request && misc_feature_enable && state == PSCF_ST_IDLE && !pending
        |=> ##1 transition_busy && op_point_apply == ($past(msr_req.data[15:0], 2) & OP_POINT_MASK))
        else $error("request write did not start a transition");
    AST_LATE_REQUEST_KEPT: assert property (@(posedge core_clk) disable iff (sys_rst) // R04
        (wr_request || pending) && transition_busy |=> pending)
        else $error("request during transition was lost");
    AST_READ_LAST_TARGET: assert property (@(posedge core_clk) disable iff (sys_rst) // R05
        msr_req.rd && msr_req.addr == PSCF_ADDR_OP_REQUEST
        |=> msr_rsp.data[15:0] == $past(operating_point_request))
        else $error("request read did not return last target");
    AST_STATUS_UPDATES: assert property (@(posedge core_clk) disable iff (sys_rst) // R06
        settle_done |=> operating_point_current == $past(op_point_apply) && !transition_busy)
        else $error("status not updated at completion");
    AST_STATUS_HOLDS: assert property (@(posedge core_clk) disable iff (sys_rst) // R16
        transition_busy && !settle_done |=> $stable(operating_point_current))
        else $error("status changed before completion");
    AST_APPLY_MASKED: assert property (@(posedge core_clk) disable iff (sys_rst) // R07
        $rose(transition_busy) |-> (op_point_apply & ~OP_POINT_MASK) == 16'h0000)
        else $error("invalid encoding applied");
    AST_FIXED_RATE: assert property (@(posedge core_clk) disable iff (sys_rst) // R09
        fixed_inc && !overflow && !sw_count_wr
        |=> fixed_rate_feedback_count == $past(fixed_rate_feedback_count) + 64'h1)
        else $error("fixed-rate counter missed a tick");
    AST_ACTUAL_RATE: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
        actual_inc && !overflow && !sw_count_wr
        |=> actual_rate_feedback_count == $past(actual_rate_feedback_count) + 64'h1)
        else $error("actual-rate counter missed a tick");
    AST_IDLE_FROZEN: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
        !active_power_state && !sw_count_wr
        |=> $stable(fixed_rate_feedback_count) && $stable(actual_rate_feedback_count))
        else $error("counter moved outside the active state");
    AST_OVERFLOW_CLEARS: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
        overflow && !sw_count_wr
        |=> fixed_rate_feedback_count == 64'h0 && actual_rate_feedback_count == 64'h0)
        else $error("overflow did not clear both counters");
    AST_WRITE_ONE_COUNTER: assert property (@(posedge core_clk) disable iff (sys_rst) // R13
        msr_req.wr && msr_req.addr == PSCF_ADDR_FIXED_RATE && !overflow && !actual_inc
        |=> fixed_rate_feedback_count == $past(msr_req.data) && $stable(actual_rate_feedback_count))
        else $error("counter write not independent");

    COV_TRANSITION: cover property (@(posedge core_clk) disable iff (sys_rst)
        $rose(transition_busy) ##[1:300] settle_done);
    COV_QUEUED: cover property (@(posedge core_clk) disable iff (sys_rst)
        wr_request && transition_busy ##[1:300] start_transition);
    COV_OVERFLOW: cover property (@(posedge core_clk) disable iff (sys_rst) overflow);

endmodule
`default_nettype wire

// ===== shared/pscf_pkg.sv
// Constants and carrier types of the operating-point control and feedback counter block.
// Assumes a single 20 MHz core clock and a synchronous active-high reset.
//
// Notes on behaviour
// [R01] The identification query advertises the transition feature in ECX bit 7.
// [R02] Transitions are possible only while bit 16 of the feature enable register is set; reset clears it.
// [R03] Writing a 16-bit target to the request register starts a transition toward it.
// [R04] A target written during a transition is kept and taken up once that transition ends.
// [R05] Reading the request register returns the last target written, not the point in effect.
// [R06] The current-point register shows the point in effect and follows every transition.
// [R07] The set of valid 16-bit encodings is an implementation parameter of the block.
// [R08] Identification query leaf 06H returns ECX bit 0 set because both feedback counters exist.
// [R09] The fixed-rate counter at E7H advances at a fixed reference rate chosen at build time.
// [R10] The actual-rate counter at E8H advances with delivered performance, throttling included.
// [R11] Each logical processor has its own counter pair, counting only in the active power state.
// [R12] An overflow of either counter clears both to zero and counting goes on.
// [R13] Both counters are 64 bits wide and each can be written on its own.
// [R14] Software saves or zeroes both counters at each decision window and spots wrap by comparison.
// [R15] Software uses only the ratio of actual-rate to fixed-rate counts.
// [R16] The current-point register changes only when the transition has completed.
package pscf_pkg;

    // ==========================================================
    // model register addresses
    localparam logic [15:0] PSCF_ADDR_FIXED_RATE   = 16'h00E7;
    localparam logic [15:0] PSCF_ADDR_ACTUAL_RATE  = 16'h00E8;
    localparam logic [15:0] PSCF_ADDR_OP_CURRENT   = 16'h0198;
    localparam logic [15:0] PSCF_ADDR_OP_REQUEST   = 16'h0199;
    localparam logic [15:0] PSCF_ADDR_MISC_ENABLE  = 16'h0100;

    // ==========================================================
    // field positions and reset values
    localparam int          PSCF_MISC_TRANSITION_BIT = 16;
    localparam logic        PSCF_MISC_ENABLE_RESET   = 1'b0;
    localparam logic [15:0] PSCF_OP_POINT_RESET      = 16'h0000;
    localparam logic [63:0] PSCF_COUNT_RESET         = 64'h0000_0000_0000_0000;

    // ==========================================================
    // identification query
    localparam logic [31:0] PSCF_LEAF_FEATURES    = 32'h0000_0001;
    localparam logic [31:0] PSCF_LEAF_POWER       = 32'h0000_0006;
    localparam int          PSCF_ID_TRANSITION_BIT = 7;
    localparam int          PSCF_ID_FEEDBACK_BIT   = 0;

    // ==========================================================
    // timing
    localparam int PSCF_CLK_PERIOD_NS     = 50;
    localparam int PSCF_SETTLE_TIME_NS    = 10000;
    localparam int PSCF_SETTLE_CYCLES     = PSCF_SETTLE_TIME_NS / PSCF_CLK_PERIOD_NS;
    localparam int PSCF_REF_PERIOD_NS     = 200;
    localparam int PSCF_REF_DIV_CYCLES    = PSCF_REF_PERIOD_NS / PSCF_CLK_PERIOD_NS;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [63:0] data;
    } pscf_msr_req_type;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [63:0] data;
    } pscf_msr_rsp_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] leaf;
    } pscf_query_req_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] ecx;
    } pscf_query_rsp_type;

    typedef enum logic [0:0] {
        PSCF_ST_IDLE   = 1'b0,
        PSCF_ST_SETTLE = 1'b1
    } pscf_state_type;

endpackage

// ===== rtl/pscf_settle_timer.sv
// Settle timer for one operating-point transition.
// Assumes start is a one-cycle pulse given only while the timer is not busy.
`timescale 1ns/1ps
`default_nettype none
module pscf_settle_timer
    import pscf_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    localparam int          DONE_DELAY = PSCF_SETTLE_CYCLES + 1;
    localparam logic [15:0] LOAD_VALUE = 16'(PSCF_SETTLE_CYCLES - 1);

    logic [15:0] count;
    logic [15:0] next_count;
    logic        next_busy;
    logic        next_done;

    // ==========================================================
    // countdown
    always_comb begin
        next_count = count;
        next_busy  = busy;
        next_done  = 1'b0;
        if (start) begin
            next_count = LOAD_VALUE;
            next_busy  = 1'b1;
        end else if (busy) begin
            if (count == 16'h0000) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = count - 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count <= 16'h0000;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            count <= next_count;
            busy  <= next_busy;
            done  <= next_done;
        end
    end

    // ==========================================================
    // checks
    AST_SETTLE_DONE_TIME: assert property (@(posedge core_clk) disable iff (sys_rst) // R16
        start |-> ##DONE_DELAY done)
        else $error("settle timer did not finish on time");

endmodule
`default_nettype wire

// ===== test/perf_state_ctl_feedback_tb.sv
// Self-checking bench for the operating-point control and feedback counter block.
// Assumes pscf_pkg is compiled first; assertions live inside the design files.
`timescale 1ns/1ps
`default_nettype none
module perf_state_ctl_feedback_tb;
    import pscf_pkg::*;

    logic               core_clk;
    logic               sys_rst;
    pscf_msr_req_type   msr_req;
    pscf_msr_rsp_type   msr_rsp;
    pscf_query_req_type query_req;
    pscf_query_rsp_type query_rsp;
    logic               active_power_state;
    logic               delivered_perf_tick;
    logic [15:0]        op_point_apply;
    logic               transition_busy;
    int                 num_errors;
    int                 checks_done;
    logic [15:0]        rnd;
    logic [63:0]        fix_m;
    logic [63:0]        act_m;

    // top bit invalid so that masking of targets is visible
    localparam logic [15:0] TB_OP_MASK = 16'h7FFF;

    pscf_core #(.OP_POINT_MASK(TB_OP_MASK)) u_pscf_core (
        .core_clk            (core_clk),
        .sys_rst             (sys_rst),
        .msr_req             (msr_req),
        .msr_rsp             (msr_rsp),
        .query_req           (query_req),
        .query_rsp           (query_rsp),
        .active_power_state  (active_power_state),
        .delivered_perf_tick (delivered_perf_tick),
        .op_point_apply      (op_point_apply),
        .transition_busy     (transition_busy)
    );

    // ==========================================================
    // clock, helpers
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic draw(output logic [63:0] v);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr_next(rnd);
            v[i*16 +: 16] = rnd;
        end
    endtask

    task automatic check(input string name, input logic [64:0] seen, input logic [64:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // register and query accesses
    task automatic msr(input logic rd, input logic wr, input logic [15:0] addr,
                       input logic [63:0] data, output pscf_msr_rsp_type rsp);
        @(posedge core_clk);
        msr_req <= '{rd: rd, wr: wr, addr: addr, data: data};
        @(posedge core_clk);
        msr_req <= '0;
        #1;
        rsp = msr_rsp;
        check("msr_rsp_valid", rsp.valid, 1'b1);
    endtask

    task automatic wr(input logic [15:0] addr, input logic [63:0] data);
        pscf_msr_rsp_type rsp;
        msr(1'b0, 1'b1, addr, data, rsp);
        check("wr_rsp", {rsp.hit, rsp.data}, {1'b1, 64'h0});
        if (addr == PSCF_ADDR_FIXED_RATE) fix_m = data;
        if (addr == PSCF_ADDR_ACTUAL_RATE) act_m = data;
    endtask

    task automatic rd(input string name, input logic [15:0] addr, input logic [64:0] exp);
        pscf_msr_rsp_type rsp;
        msr(1'b1, 1'b0, addr, 64'h0, rsp);
        check(name, {rsp.hit, rsp.data}, exp);
    endtask

    task automatic query(input logic [31:0] leaf, output logic [31:0] ecx);
        @(posedge core_clk);
        query_req <= '{valid: 1'b1, leaf: leaf};
        @(posedge core_clk);
        query_req <= '0;
        #1;
        check("query_rsp_valid", query_rsp.valid, 1'b1);
        ecx = query_rsp.ecx;
    endtask

    task automatic wait_busy(input logic lvl, output int n);
        n = 0;
        while (transition_busy !== lvl && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("busy_wait", n < 400, 1'b1);
    endtask

    // ==========================================================
    // counter activity with its reference model
    // n is a multiple of 4 unless the window is a single wrapping tick,
    // so the free-running divider phase never matters
    task automatic run(input int n, input logic act, input int nticks);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            active_power_state  <= act;
            delivered_perf_tick <= (i < nticks);
        end
        @(posedge core_clk);
        active_power_state  <= 1'b0;
        delivered_perf_tick <= 1'b0;
        if (act) begin
            for (int i = 0; i < nticks; i++) begin
                if (&act_m) {fix_m, act_m} = '0;
                else act_m++;
            end
            for (int i = 0; i < n / 4; i++) begin
                if (&fix_m) {fix_m, act_m} = '0;
                else fix_m++;
            end
        end
        rd("fixed_count", PSCF_ADDR_FIXED_RATE, {1'b1, fix_m});
        rd("actual_count", PSCF_ADDR_ACTUAL_RATE, {1'b1, act_m});
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] ecx;
        logic [63:0] v;
        logic [15:0] t1;
        logic [15:0] t2;
        int          n;
        sys_rst = 1'b1;
        msr_req = '0;
        query_req = '0;
        active_power_state = 1'b0;
        delivered_perf_tick = 1'b0;
        num_errors = 0;
        checks_done = 0;
        rnd = 16'h67F0;
        fix_m = '0;
        act_m = '0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        query(PSCF_LEAF_FEATURES, ecx);
        check("id_transition", ecx[PSCF_ID_TRANSITION_BIT], 1'b1);
        query(PSCF_LEAF_POWER, ecx);
        check("id_feedback", ecx[PSCF_ID_FEEDBACK_BIT], 1'b1);
        query(32'h0000_1234, ecx);
        check("id_unknown", ecx, 32'h0);
        rd("misc_reset", PSCF_ADDR_MISC_ENABLE, {1'b1, 64'h0});
        rd("unmapped", 16'h0123, 65'h0);
        draw(v);
        t1 = v[15:0] | 16'h8000;
        t2 = t1 ^ 16'h00FF;
        // request held back while the feature is off
        wr(PSCF_ADDR_OP_REQUEST, {48'h0, t1});
        repeat (6) @(posedge core_clk);
        #1;
        check("busy_disabled", transition_busy, 1'b0);
        rd("request_rd", PSCF_ADDR_OP_REQUEST, {1'b1, 48'h0, t1});
        wr(PSCF_ADDR_MISC_ENABLE, 64'h0000_0000_0001_0000);
        rd("misc_rd", PSCF_ADDR_MISC_ENABLE, {1'b1, 64'h0000_0000_0001_0000});
        wait_busy(1'b1, n);
        check("apply_t1", op_point_apply, t1 & TB_OP_MASK);
        wr(PSCF_ADDR_OP_REQUEST, {48'h0, t2});
        rd("request_last", PSCF_ADDR_OP_REQUEST, {1'b1, 48'h0, t2});
        rd("current_old", PSCF_ADDR_OP_CURRENT, {1'b1, 64'h0});
        wait_busy(1'b0, n);
        wait_busy(1'b1, n);
        check("apply_t2", op_point_apply, t2 & TB_OP_MASK);
        wait_busy(1'b0, n);
        // busy covers the settle count plus the cycle that takes up done
        check("settle_len", n, PSCF_SETTLE_CYCLES + 1);
        rd("current_t2", PSCF_ADDR_OP_CURRENT, {1'b1, 48'h0, t2 & TB_OP_MASK});
        wr(PSCF_ADDR_OP_CURRENT, 64'h0000_0000_0000_ABCD);
        rd("current_ro", PSCF_ADDR_OP_CURRENT, {1'b1, 48'h0, t2 & TB_OP_MASK});
        // request while idle and enabled starts at once
        wr(PSCF_ADDR_OP_REQUEST, {48'h0, t1});
        wait_busy(1'b1, n);
        check("apply_idle", op_point_apply, t1 & TB_OP_MASK);
        wait_busy(1'b0, n);
        rd("current_t1", PSCF_ADDR_OP_CURRENT, {1'b1, 48'h0, t1 & TB_OP_MASK});
        // switching the feature off again holds a new request back
        wr(PSCF_ADDR_MISC_ENABLE, 64'h0);
        wr(PSCF_ADDR_OP_REQUEST, {48'h0, t2});
        repeat (4) @(posedge core_clk);
        #1;
        check("busy_off", transition_busy, 1'b0);
        // feedback counters
        run(0, 1'b0, 0);
        run(8, 1'b1, 3);
        run(8, 1'b0, 5);
        draw(v);
        wr(PSCF_ADDR_FIXED_RATE, v);
        run(0, 1'b0, 0);
        draw(v);
        wr(PSCF_ADDR_ACTUAL_RATE, v);
        run(0, 1'b0, 0);
        wr(PSCF_ADDR_FIXED_RATE, 64'h0);
        wr(PSCF_ADDR_ACTUAL_RATE, 64'h0);
        run(0, 1'b0, 0);
        run(16, 1'b1, 8);
        wr(PSCF_ADDR_ACTUAL_RATE, 64'hFFFF_FFFF_FFFF_FFFF);
        wr(PSCF_ADDR_FIXED_RATE, 64'h0000_0000_0000_0050);
        run(1, 1'b1, 1);
        run(4, 1'b1, 2);
        wr(PSCF_ADDR_FIXED_RATE, 64'hFFFF_FFFF_FFFF_FFFF);
        wr(PSCF_ADDR_ACTUAL_RATE, 64'h0000_0000_0000_0005);
        run(4, 1'b1, 0);
        tally_and_finish;
    end

    // ==========================================================
    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        tally_and_finish;
    end

endmodule
`default_nettype wire
